// [verilog/wake_power_pkg.sv]
// Purpose: Shared types and constants for the wake event and power control block.
// Assumes: One always-on standby clock at 100 MHz with a synchronous reset.
// Notes: Input bit positions index the synchroniser bundle in the main module.
package wake_power_pkg;

    typedef enum logic [2:0] {
        pw_working,
        pw_s1,
        pw_s3,
        pw_soft_off,
        pw_apm_sleep,
        pw_apm_off,
        pw_outage
    } power_state_t;

    typedef enum logic [1:0] {
        req_s1,
        req_s3,
        req_soft_off,
        req_apm_sleep
    } sleep_req_t;

    // Positions of the pin inputs inside the synchroniser bundle.
    localparam int SYNC_W = 9;
    localparam int IN_RING_A = 0;
    localparam int IN_RING_HDR = 1;
    localparam int IN_NET_WAKE = 2;
    localparam int IN_PME_N = 3;
    localparam int IN_USB = 4;
    localparam int IN_KBD = 5;
    localparam int IN_MAINS = 6;
    localparam int IN_STBY = 7;
    localparam int IN_LED_DUAL = 8;

    // The PCI event line is active low, so its idle level after reset is one.
    localparam logic [SYNC_W-1:0] SYNC_RESET = 9'h008;

endpackage

// [verilog/pin_sync.sv]
// Purpose: Two-stage synchroniser for a bundle of pin levels.
// Assumes: Inputs are asynchronous levels; each bit is an independent signal.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Levels
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            meta_q <= RESET_VAL;
            q <= RESET_VAL;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end

endmodule // pin_sync

// [verilog/wake_event_power_control.sv]
// Purpose: Wake decision and power state control running on the standby clock.
// Assumes: Software controls arrive synchronous to clk; all pins are asynchronous.
// Notes: The second serial port's ring detect has no port at all, as it never wakes the system.
`timescale 1ns/1ps
module wake_event_power_control (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Wake source pins, asynchronous
    input wire logic ring_detect_input,
    input wire logic ring_header_wake,
    input wire logic net_wake_header,
    input wire logic pme_n,
    input wire logic usb_activity,
    input wire logic kbd_activity,
    // Supply and board status pins, asynchronous
    input wire logic mains_good,
    input wire logic standby_present,
    input wire logic led_dual_colour,
    // Software control, synchronous
    input wire logic apm_mode,
    input wire logic soft_off_en,
    input wire logic sleep_req,
    input wire wake_power_pkg::sleep_req_t sleep_kind,
    // Supply, fans and indicators
    output logic ps_on_n_q,
    output logic sys_fan_on_q,
    output logic psu_fan_on_q,
    output logic led_green_q,
    output logic led_amber_q,
    output logic standby_led_q,
    // Events and state
    output logic wake_pulse_q,
    output logic ring_resume_irq_q,
    output logic access_grant_q,
    output wake_power_pkg::power_state_t power_state_q
);

    logic [wake_power_pkg::SYNC_W-1:0] pins_raw;
    logic [wake_power_pkg::SYNC_W-1:0] pins_s;
    logic ring_a_s;
    logic ring_hdr_s;
    logic net_s;
    logic pme_s;
    logic usb_s;
    logic kbd_s;
    logic mains_s;
    logic stby_s;
    logic led_dual_s;
    logic ring_a_d_q;
    logic ring_hdr_d_q;
    logic ring_a_rise;
    logic ring_hdr_rise;
    logic sleep_wake;
    logic net_wake_ok;
    logic ring_wake_off;
    logic ring_resume;
    logic wake_any;
    logic last_on_q;
    logic ring_armed_q;
    logic supply_on;
    wake_power_pkg::power_state_t state_d;

    assign pins_raw[wake_power_pkg::IN_RING_A] = ring_detect_input;
    assign pins_raw[wake_power_pkg::IN_RING_HDR] = ring_header_wake;
    assign pins_raw[wake_power_pkg::IN_NET_WAKE] = net_wake_header;
    assign pins_raw[wake_power_pkg::IN_PME_N] = pme_n;
    assign pins_raw[wake_power_pkg::IN_USB] = usb_activity;
    assign pins_raw[wake_power_pkg::IN_KBD] = kbd_activity;
    assign pins_raw[wake_power_pkg::IN_MAINS] = mains_good;
    assign pins_raw[wake_power_pkg::IN_STBY] = standby_present;
    assign pins_raw[wake_power_pkg::IN_LED_DUAL] = led_dual_colour;

    pin_sync #(
        .WIDTH(wake_power_pkg::SYNC_W),
        .RESET_VAL(wake_power_pkg::SYNC_RESET)
    ) u_pin_sync (
        .clk(clk),
        .srst(srst),
        .d(pins_raw),
        .q(pins_s)
    );

    assign ring_a_s = pins_s[wake_power_pkg::IN_RING_A];
    assign ring_hdr_s = pins_s[wake_power_pkg::IN_RING_HDR];
    assign net_s = pins_s[wake_power_pkg::IN_NET_WAKE];
    assign pme_s = ~pins_s[wake_power_pkg::IN_PME_N];
    assign usb_s = pins_s[wake_power_pkg::IN_USB];
    assign kbd_s = pins_s[wake_power_pkg::IN_KBD];
    assign mains_s = pins_s[wake_power_pkg::IN_MAINS];
    assign stby_s = pins_s[wake_power_pkg::IN_STBY];
    assign led_dual_s = pins_s[wake_power_pkg::IN_LED_DUAL];

    // Each ring is counted once, on its rising edge, so a long ring is one call.
    always_ff @(posedge clk) begin
        if (srst) begin
            ring_a_d_q <= 1'b0;
            ring_hdr_d_q <= 1'b0;
        end else begin
            ring_a_d_q <= ring_a_s;
            ring_hdr_d_q <= ring_hdr_s;
        end
    end

    assign ring_a_rise = ring_a_s & ~ring_a_d_q;
    assign ring_hdr_rise = ring_hdr_s & ~ring_hdr_d_q;

    always_comb begin
        sleep_wake = 1'b0;
        net_wake_ok = 1'b0;
        ring_wake_off = 1'b0;
        ring_resume = 1'b0;
        if (power_state_q == wake_power_pkg::pw_s1 || power_state_q == wake_power_pkg::pw_s3) begin
            sleep_wake = usb_s | kbd_s | pme_s;
        end
        if (power_state_q == wake_power_pkg::pw_apm_off ||
            power_state_q == wake_power_pkg::pw_apm_sleep ||
            power_state_q == wake_power_pkg::pw_soft_off) begin
            net_wake_ok = net_s;
        end
        if (power_state_q == wake_power_pkg::pw_apm_off) begin
            ring_wake_off = ring_a_rise | ring_hdr_rise;
        end
        if (power_state_q == wake_power_pkg::pw_apm_sleep ||
            power_state_q == wake_power_pkg::pw_s1) begin
            ring_resume = ring_a_rise;
        end
    end

    assign wake_any = sleep_wake | net_wake_ok | ring_wake_off | ring_resume;

    // Loss of mains outranks everything, then a sleep request, then a wake.
    always_comb begin
        state_d = power_state_q;
        case (power_state_q)
            wake_power_pkg::pw_outage: begin
                if (mains_s) begin
                    if (soft_off_en && last_on_q) begin
                        state_d = wake_power_pkg::pw_working;
                    end else if (apm_mode) begin
                        state_d = wake_power_pkg::pw_apm_off;
                    end else begin
                        state_d = wake_power_pkg::pw_soft_off;
                    end
                end
            end
            wake_power_pkg::pw_working: begin
                if (!mains_s) begin
                    state_d = wake_power_pkg::pw_outage;
                end else if (sleep_req) begin
                    case (sleep_kind)
                        wake_power_pkg::req_s1: state_d = wake_power_pkg::pw_s1;
                        wake_power_pkg::req_s3: state_d = wake_power_pkg::pw_s3;
                        wake_power_pkg::req_apm_sleep: state_d = wake_power_pkg::pw_apm_sleep;
                        wake_power_pkg::req_soft_off: begin
                            state_d = apm_mode ? wake_power_pkg::pw_apm_off
                                               : wake_power_pkg::pw_soft_off;
                        end
                        default: state_d = power_state_q;
                    endcase
                end
            end
            wake_power_pkg::pw_s1,
            wake_power_pkg::pw_s3,
            wake_power_pkg::pw_soft_off,
            wake_power_pkg::pw_apm_sleep,
            wake_power_pkg::pw_apm_off: begin
                if (!mains_s) begin
                    state_d = wake_power_pkg::pw_outage;
                end else if (wake_any) begin
                    state_d = wake_power_pkg::pw_working;
                end
            end
            default: state_d = wake_power_pkg::pw_outage;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            power_state_q <= wake_power_pkg::pw_outage;
        end else begin
            power_state_q <= state_d;
        end
    end

    // The on/off memory freezes during an outage so that the restore sees the old state.
    always_ff @(posedge clk) begin
        if (srst) begin
            last_on_q <= 1'b0;
        end else if (mains_s && power_state_q != wake_power_pkg::pw_outage) begin
            last_on_q <= power_state_q != wake_power_pkg::pw_soft_off &&
                         power_state_q != wake_power_pkg::pw_apm_off;
        end
    end

    // First call only powers up; a later ring on ring_detect_input while running grants access.
    always_ff @(posedge clk) begin
        if (srst) begin
            ring_armed_q <= 1'b0;
            access_grant_q <= 1'b0;
        end else begin
            access_grant_q <= ring_armed_q && ring_a_rise &&
                              power_state_q == wake_power_pkg::pw_working;
            if (ring_wake_off) begin
                ring_armed_q <= 1'b1;
            end else if (power_state_q != wake_power_pkg::pw_working ||
                         (ring_a_rise && ring_armed_q)) begin
                ring_armed_q <= 1'b0;
            end
        end
    end

    // Ring resume is handed to software as a modem interrupt request.
    always_ff @(posedge clk) begin
        if (srst) begin
            ring_resume_irq_q <= 1'b0;
            wake_pulse_q <= 1'b0;
        end else begin
            ring_resume_irq_q <= ring_resume && mains_s;
            wake_pulse_q <= wake_any && mains_s &&
                            power_state_q != wake_power_pkg::pw_outage;
        end
    end

    assign supply_on = power_state_q == wake_power_pkg::pw_working ||
                       power_state_q == wake_power_pkg::pw_s1 ||
                       power_state_q == wake_power_pkg::pw_apm_sleep;

    always_ff @(posedge clk) begin
        if (srst) begin
            ps_on_n_q <= 1'b1;
            sys_fan_on_q <= 1'b0;
            psu_fan_on_q <= 1'b0;
            led_green_q <= 1'b0;
            led_amber_q <= 1'b0;
            standby_led_q <= 1'b0;
        end else begin
            ps_on_n_q <= ~supply_on;
            sys_fan_on_q <= supply_on;
            psu_fan_on_q <= supply_on;
            led_green_q <= supply_on;
            led_amber_q <= power_state_q == wake_power_pkg::pw_s3 && led_dual_s;
            standby_led_q <= stby_s;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    a_s3_supply_off: assert property (
        power_state_q == wake_power_pkg::pw_s3 |=> ps_on_n_q && !sys_fan_on_q && !psu_fan_on_q)
        else $error("supply or fan on in S3");
    a_s3_led_colour: assert property (
        power_state_q == wake_power_pkg::pw_s3
        |=> !led_green_q && led_amber_q == $past(led_dual_s))
        else $error("wrong indicator in S3");
    a_usb_wakes: assert property (
        (power_state_q == wake_power_pkg::pw_s1 || power_state_q == wake_power_pkg::pw_s3)
        && usb_s && mains_s |=> power_state_q == wake_power_pkg::pw_working ##1 !ps_on_n_q)
        else $error("USB activity did not wake");
    a_kbd_wakes: assert property (
        power_state_q == wake_power_pkg::pw_s3 && kbd_s && mains_s
        |=> ##1 !ps_on_n_q && sys_fan_on_q)
        else $error("keyboard did not wake from S3");
    a_pme_wakes: assert property (
        power_state_q == wake_power_pkg::pw_s1 && pme_s && mains_s
        |=> power_state_q == wake_power_pkg::pw_working)
        else $error("PME did not wake from S1");
    a_net_gated: assert property (
        power_state_q == wake_power_pkg::pw_soft_off && net_s && mains_s
        |=> power_state_q == wake_power_pkg::pw_working)
        else $error("network wake ignored in S5");
    a_soft_off_req: assert property (
        power_state_q == wake_power_pkg::pw_working && sleep_req && mains_s &&
        sleep_kind == wake_power_pkg::req_soft_off |=> ##1 ps_on_n_q && !sys_fan_on_q)
        else $error("soft-off did not cut supply");
    a_restore_on: assert property (
        power_state_q == wake_power_pkg::pw_outage && mains_s && soft_off_en && last_on_q
        |=> power_state_q == wake_power_pkg::pw_working)
        else $error("previous on state not restored");
    a_ring_access: assert property (
        access_grant_q
        |-> $past(ring_armed_q) && $past(power_state_q) == wake_power_pkg::pw_working)
        else $error("access granted without a first call");
    a_ring_resume: assert property (
        ring_resume_irq_q |-> power_state_q == wake_power_pkg::pw_working && $past(ring_a_rise))
        else $error("ring resume without ring");
    a_standby_led: assert property (
        stby_s [*2] |-> standby_led_q)
        else $error("standby indicator dark with standby power");
    a_fans_follow: assert property (
        power_state_q == wake_power_pkg::pw_s1 |=> sys_fan_on_q && psu_fan_on_q)
        else $error("fans off in S1");

    c_s3_wake: cover property (power_state_q == wake_power_pkg::pw_s3
        ##1 power_state_q == wake_power_pkg::pw_working);
    c_ring_access: cover property (access_grant_q);
    c_outage_restore: cover property (power_state_q == wake_power_pkg::pw_outage
        ##1 power_state_q == wake_power_pkg::pw_working);
    c_ring_resume: cover property (ring_resume_irq_q);

endmodule // wake_event_power_control

// [dv/wake_partner.sv]
// Purpose: Far-side model of the supply and the wake-capable peripherals.
// Assumes: The bench pulses ev_go for one cycle to fire one wake source.
// Notes: A source holds its level four cycles, long enough to cross the synchroniser.
`timescale 1ns/1ps
module wake_partner (
    // Clock
    input wire logic clk,
    // Commands from the bench
    input wire logic ev_go,
    input wire logic [2:0] ev_sel,
    input wire logic mains_cmd,
    input wire logic stby_cmd,
    // Pins toward the block
    output logic ring_detect_input,
    output logic ring_header_wake,
    output logic net_wake_header,
    output logic pme_n,
    output logic usb_activity,
    output logic kbd_activity,
    output logic mains_good,
    output logic standby_present
);
    logic [2:0] len_q = 3'h0;
    logic [2:0] sel_q = 3'h0;
    logic act;
    always_ff @(posedge clk) begin
        if (ev_go) begin
            sel_q <= ev_sel;
            len_q <= 3'h4;
        end else if (len_q != 3'h0) begin
            len_q <= len_q - 3'h1;
        end
    end
    assign act = len_q != 3'h0;
    // The modem interrupt stays unmasked, so a ring reaches the resume path in S1 and APM sleep.
    assign ring_detect_input = act && sel_q == 3'h0;
    // An internal modem without bus event support uses the header cable.
    assign ring_header_wake = act && sel_q == 3'h1;
    assign net_wake_header = act && sel_q == 3'h2;
    assign pme_n = !(act && sel_q == 3'h3);
    assign usb_activity = act && sel_q == 3'h4;
    assign kbd_activity = act && sel_q == 3'h5;
    assign mains_good = mains_cmd;
    assign standby_present = mains_cmd && stby_cmd;
endmodule // wake_partner

// [dv/wake_event_power_control_bench.sv]
// Purpose: Self-checking bench for the wake event and power control block.
// Assumes: The partner drives every pin except led_dual_colour; software controls and led_dual_colour are driven here.
// Notes: The driver notes each expected state change; the monitor checks them in order.
`timescale 1ns/1ps
module wake_event_power_control_bench;
    typedef struct {
        wake_power_pkg::power_state_t st;
        int w;
    } note_t;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic ev_go = 1'b0;
    logic [2:0] ev_sel = 3'h0;
    logic mains_cmd = 1'b0;
    logic stby_cmd = 1'b1;
    logic led_dual_colour = 1'b0;
    logic apm_mode = 1'b0;
    logic soft_off_en = 1'b0;
    logic sleep_req = 1'b0;
    wake_power_pkg::sleep_req_t sleep_kind = wake_power_pkg::req_s1;
    logic ring_detect_input, ring_header_wake, net_wake_header, pme_n;
    logic usb_activity, kbd_activity, mains_good, standby_present;
    logic ps_on_n_q, sys_fan_on_q, psu_fan_on_q, led_green_q, led_amber_q;
    logic standby_led_q, wake_pulse_q, ring_resume_irq_q, access_grant_q;
    wake_power_pkg::power_state_t power_state_q, last_st;
    note_t notes[$];
    note_t n;
    int err_total = 0;
    int comparisons = 0;
    int irq_seen = 0;
    int grant_seen = 0;
    int seed = 97;
    int k, j;

    wake_partner wake_partner_i (.clk(clk), .ev_go(ev_go), .ev_sel(ev_sel),
        .mains_cmd(mains_cmd), .stby_cmd(stby_cmd), .ring_detect_input(ring_detect_input),
        .ring_header_wake(ring_header_wake), .net_wake_header(net_wake_header), .pme_n(pme_n),
        .usb_activity(usb_activity), .kbd_activity(kbd_activity), .mains_good(mains_good),
        .standby_present(standby_present));

    wake_event_power_control wake_event_power_control_i (.clk(clk), .srst(srst),
        .ring_detect_input(ring_detect_input), .ring_header_wake(ring_header_wake),
        .net_wake_header(net_wake_header), .pme_n(pme_n), .usb_activity(usb_activity),
        .kbd_activity(kbd_activity), .mains_good(mains_good),
        .standby_present(standby_present), .led_dual_colour(led_dual_colour),
        .apm_mode(apm_mode), .soft_off_en(soft_off_en), .sleep_req(sleep_req),
        .sleep_kind(sleep_kind), .ps_on_n_q(ps_on_n_q), .sys_fan_on_q(sys_fan_on_q),
        .psu_fan_on_q(psu_fan_on_q), .led_green_q(led_green_q), .led_amber_q(led_amber_q),
        .standby_led_q(standby_led_q), .wake_pulse_q(wake_pulse_q),
        .ring_resume_irq_q(ring_resume_irq_q), .access_grant_q(access_grant_q),
        .power_state_q(power_state_q));

    initial begin
        forever #5 clk = ~clk;
    end

    task miss(input string m);
        err_total++;
        $display("MISMATCH at %0t: %s", $time, m);
    endtask

    task close_out;
        $display("comparisons %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task chk(input logic ok, input string m);
        comparisons++;
        if (ok !== 1'b1) miss(m);
    endtask

    task chk_out(input wake_power_pkg::power_state_t s);
        logic on;
        logic amb;
        on = s inside {wake_power_pkg::pw_working, wake_power_pkg::pw_s1,
            wake_power_pkg::pw_apm_sleep};
        amb = s == wake_power_pkg::pw_s3 && led_dual_colour;
        chk(ps_on_n_q === !on && sys_fan_on_q === on && psu_fan_on_q === on,
            "supply or fans");
        chk(led_green_q === on && led_amber_q === amb, "front led");
        chk(standby_led_q === (mains_cmd && stby_cmd), "standby led");
    endtask

    // Codes 0 to 5 fire a pin, 8 to 11 a sleep request, 12 and 13 drop or restore mains.
    task go(input int sel, input wake_power_pkg::power_state_t s, input int w);
        int i;
        logic chg;
        chg = s !== power_state_q;
        if (chg) notes.push_back('{s, w});
        @(posedge clk);
        if (sel < 8) begin
            ev_sel <= 3'(sel);
            ev_go <= 1'b1;
        end else if (sel < 12) begin
            sleep_req <= 1'b1;
            sleep_kind <= wake_power_pkg::sleep_req_t'(2'(sel - 8));
        end else begin
            mains_cmd <= sel == 13;
        end
        @(posedge clk);
        ev_go <= 1'b0;
        sleep_req <= 1'b0;
        for (i = 0; i < 12 && notes.size() != 0; i++) @(posedge clk);
        if (notes.size() != 0) begin
            miss("state change never came");
            close_out;
        end
        if (!chg) repeat (8) @(posedge clk);
        @(negedge clk);
        chk(power_state_q === s, "state after event");
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk_out(s);
        repeat (1 + $unsigned($random(seed)) % 4) @(posedge clk);
    endtask

    // Only moves of the state are judged here; refused events are judged by the driver.
    always @(negedge clk) begin
        if (srst) begin
            last_st = power_state_q;
        end else begin
            if (power_state_q !== last_st) begin
                if (notes.size() == 0) begin
                    miss("state moved with no cause");
                end else begin
                    n = notes.pop_front();
                    chk(power_state_q === n.st && (n.w > 1 || wake_pulse_q === n.w[0]),
                        "move");
                end
            end
            last_st = power_state_q;
            if (ring_resume_irq_q === 1'b1) irq_seen++;
            if (access_grant_q === 1'b1) grant_seen++;
        end
    end

    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        chk(power_state_q === wake_power_pkg::pw_outage && ps_on_n_q === 1'b1, "reset");
        go(13, wake_power_pkg::pw_soft_off, 0);
        go(4, wake_power_pkg::pw_soft_off, 0);
        go(2, wake_power_pkg::pw_working, 1);
        $display("test cold start and network wake done");
        for (k = 0; k < 2; k++) begin
            for (j = 0; j < 3; j++) begin
                led_dual_colour <= 1'($random(seed));
                go(8 + k, k ? wake_power_pkg::pw_s3 : wake_power_pkg::pw_s1, 0);
                go(j == 2 ? 3 : 4 + j, wake_power_pkg::pw_working, 1);
            end
        end
        go(9, wake_power_pkg::pw_s3, 0);
        go(2, wake_power_pkg::pw_s3, 0);
        go(1, wake_power_pkg::pw_s3, 0);
        go(10, wake_power_pkg::pw_s3, 0);
        go(0, wake_power_pkg::pw_s3, 0);
        go(5, wake_power_pkg::pw_working, 1);
        $display("test sleep and wake sources done");
        go(8, wake_power_pkg::pw_s1, 0);
        go(0, wake_power_pkg::pw_working, 1);
        go(11, wake_power_pkg::pw_apm_sleep, 0);
        go(0, wake_power_pkg::pw_working, 1);
        chk(irq_seen == 2 && grant_seen == 0, "ring resume interrupt count");
        $display("test ring resume done");
        apm_mode <= 1'b1;
        go(10, wake_power_pkg::pw_apm_off, 0);
        go(4, wake_power_pkg::pw_apm_off, 0);
        go(1, wake_power_pkg::pw_working, 1);
        go(0, wake_power_pkg::pw_working, 0);
        chk(grant_seen == 1 && irq_seen == 2, "second call grant");
        $display("test ring wake done");
        soft_off_en <= 1'b1;
        go(12, wake_power_pkg::pw_outage, 0);
        go(13, wake_power_pkg::pw_working, 2);
        go(10, wake_power_pkg::pw_apm_off, 0);
        go(12, wake_power_pkg::pw_outage, 0);
        go(13, wake_power_pkg::pw_apm_off, 2);
        stby_cmd <= 1'b0;
        repeat (6) @(posedge clk);
        @(negedge clk);
        chk(standby_led_q === 1'b0, "standby led off");
        $display("test outage restore and standby done");
        close_out;
    end
endmodule // wake_event_power_control_bench
